// *** design/reset_and_watchdog.v ***
`timescale 1ns/1ns
`include "reset_and_watchdog_regs.vh"
// Notes on behaviour
// - Reset from pin, power-on, or watchdog expiry.
// - Stay in reset while pin held low.
// - Reset halts core, inputs pulled up, oscillator restarted.
// - Reset in stop starts oscillator, pulls up inputs.
// - Hold internal reset 2048 cycles after release.
// - Power-on: delay starts once oscillator runs.
// - Watchdog reset uses full stabilisation delay.
// - Watchdog expiry reinitialises watchdog counter.
// - Leaving reset clears stack, loads reset vector.
// - Start in NMI context, interrupt flag set.
// - Ending return services pending interrupt first.
// - Timer 1 control 00h, counter FFh, prescaler 7Fh.
// - Reset when downcounter bit 6 falls; software reloads.
// - Software option: enable sticks until device reset.
// - Stop mode allowed while watchdog disabled.
// - Hardware option: always on, stop acts as wait.
// - Watchdog resumes counting after stop wake-up.
// - Register resets to FEh, longest timeout.
// - Software-reset bit one-to-zero forces reset.
// - Count bits map reversed onto downcounter.
// - 64 periods; expiry when counter bit 6 falls.
// - Hardware option: activate bit reads one.
// - Inactive watchdog acts as plain 7-bit timer.
module reset_and_watchdog #(
  parameter STAB_CYCLES = `STAB_CYCLES,
  parameter TICK_CYCLES = `WDOG_TICK_CYCLES
) (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        ext_reset_b,
  input  wire        osc_running,
  input  wire        hw_watchdog_option,
  input  wire [7:0]  data_addr,
  input  wire [7:0]  data_wdata,
  input  wire        data_write,
  input  wire        data_read,
  input  wire        stop_request,
  input  wire        wake_interrupt,
  input  wire        interrupt_pending,
  input  wire        return_from_interrupt,
  output reg  [7:0]  data_rdata,
  output reg         data_hit,
  output wire        core_halt,
  output wire        io_pullup_inputs,
  output wire        osc_restart,
  output reg         init_strobe,
  output reg  [11:0] reset_pc,
  output reg         stack_clear,
  output reg         nmi_context,
  output reg         service_pending,
  output wire        stop_enter,
  output wire        wait_enter,
  output reg  [7:0]  tmr1_ctrl,
  output reg  [7:0]  tmr1_count,
  output reg  [6:0]  tmr1_presc,
  output wire        watchdog_active,
  output wire        internal_reset
);

// ==========================================================================
// Reset merging
// ==========================================================================
  reg        wdog_expire_r;
  reg        swrst_fire_r;
  reg        por_done_r;
  wire       stab_busy;
  wire       src_active;

  // Power-on is modelled by rst_b; the delay only begins once the
  // oscillator runs, so osc_running low keeps the counter loaded.
  assign src_active = !ext_reset_b || !osc_running || !por_done_r ||
                      wdog_expire_r || swrst_fire_r;

  stab_counter #(
    .CYCLES (STAB_CYCLES),
    .WIDTH  (12)
  ) u_stab (
    .clock (clock),
    .rst_b (rst_b),
    .hold  (src_active),
    .busy  (stab_busy)
  );

  assign internal_reset   = stab_busy;
  assign core_halt        = stab_busy;
  assign io_pullup_inputs = stab_busy;
  assign osc_restart      = src_active;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      por_done_r <= 1'b0;
    end else if (osc_running) begin
      por_done_r <= 1'b1;
    end
  end

// ==========================================================================
// Initialisation sequence
// ==========================================================================
  reg stab_busy_d_r;
  reg nmi_nxt;
  reg service_nxt;

  // Leaving the NMI context needs the core's return; a reset source that
  // is still active keeps the core in it whatever the core does.
  always @* begin
    nmi_nxt     = nmi_context;
    service_nxt = 1'b0;
    if (stab_busy) begin
      nmi_nxt = 1'b1;
    end else if (nmi_context && return_from_interrupt) begin
      nmi_nxt     = 1'b0;
      service_nxt = interrupt_pending;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stab_busy_d_r   <= 1'b1;
      init_strobe     <= 1'b0;
      reset_pc        <= `RESET_VECTOR;
      stack_clear     <= 1'b1;
      nmi_context     <= 1'b1;
      service_pending <= 1'b0;
    end else begin
      stab_busy_d_r   <= stab_busy;
      init_strobe     <= stab_busy_d_r && !stab_busy;
      reset_pc        <= `RESET_VECTOR;
      stack_clear     <= stab_busy;
      nmi_context     <= nmi_nxt;
      service_pending <= service_nxt;
    end
  end

// ==========================================================================
// Timer 1 reset values
// ==========================================================================
  // Only the reset image is held here; the timer itself lives elsewhere.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tmr1_ctrl  <= `TMR1_CTRL_RESET;
      tmr1_count <= `TMR1_COUNT_RESET;
      tmr1_presc <= `TMR1_PRESC_RESET;
    end else if (stab_busy) begin
      tmr1_ctrl  <= `TMR1_CTRL_RESET;
      tmr1_count <= `TMR1_COUNT_RESET;
      tmr1_presc <= `TMR1_PRESC_RESET;
    end else begin
      tmr1_ctrl  <= tmr1_ctrl;
      tmr1_count <= tmr1_count;
      tmr1_presc <= tmr1_presc;
    end
  end

// ==========================================================================
// Watchdog register and downcounter
// ==========================================================================
  // cnt_r is the physical 7-bit downcounter; bit 6 is the software-reset
  // bit and bits 5..0 hold the count, mirrored against register bits 2..7.
  reg  [6:0] cnt_r;
  reg  [6:0] cnt_nxt;
  reg        act_r;
  reg  [3:0] tick_r;
  reg        stopped_r;
  wire       wr_hit;
  wire       tick;
  wire [7:0] reg_view;

  function [5:0] reverse6;
    input [5:0] v;
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        reverse6[i] = v[5-i];
      end
    end
  endfunction

  // The register decode is shared by the write and the read path.
  function is_wdog_addr;
    input [7:0] a;
    begin
      is_wdog_addr = (a == `WDOG_REG_ADDR);
    end
  endfunction

  wire [5:0] count_view;
  genvar     g;

  // Register bits 7..2 show counter bits 0..5.
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_view
      assign count_view[g] = cnt_r[5-g];
    end
  endgenerate

  assign wr_hit = data_write && is_wdog_addr(data_addr);
  assign watchdog_active = act_r || hw_watchdog_option;
  assign reg_view = {count_view, cnt_r[6], watchdog_active};

  // 12 clocks per prescale increment, 256 increments per count step gives 3072
  // cycles per step, since the count sits above an 8-bit prescale.
  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam [3:0]   TICK_LAST   = TICK_LAST_I[3:0];
  reg [7:0] pre_r;
  reg [7:0] pre_nxt;
  reg [3:0] tick_nxt;
  assign tick = (tick_r == TICK_LAST) && (pre_r == 8'hFF);

  // A write restarts the prescale, so a reload always buys a full step.
  // The prescale is held at zero while stopped, which is what freezes the
  // count in stop mode.
  always @* begin
    tick_nxt = tick_r + 4'h1;
    pre_nxt  = pre_r;
    if (stab_busy || wr_hit || stopped_r) begin
      tick_nxt = 4'h0;
      pre_nxt  = 8'h00;
    end else if (tick_r == TICK_LAST) begin
      tick_nxt = 4'h0;
      pre_nxt  = pre_r + 8'h01;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_r <= 4'h0;
      pre_r  <= 8'h00;
    end else begin
      tick_r <= tick_nxt;
      pre_r  <= pre_nxt;
    end
  end

  always @* begin
    cnt_nxt = cnt_r;
    if (wr_hit) begin
      cnt_nxt = {data_wdata[`WDOG_SWRST_BIT],
                 reverse6(data_wdata[7:2])};
    end else if (tick && cnt_r != 7'h00) begin
      cnt_nxt = cnt_r - 7'h01;
    end
  end

  reg act_nxt;
  reg expire_nxt;
  reg swrst_nxt;

  always @* begin
    act_nxt = act_r;
    if (wr_hit && data_wdata[`WDOG_ACT_BIT]) begin
      act_nxt = 1'b1;
    end
    // Expiry when bit 6 falls; it fires only while the watchdog runs.
    expire_nxt = watchdog_active && cnt_r[6] &&
                 !cnt_nxt[6] && !wr_hit;
    // A written one-to-zero on the software-reset bit always resets.
    swrst_nxt  = wr_hit && cnt_r[6] &&
                 !data_wdata[`WDOG_SWRST_BIT];
  end

  // Any reset source reloads the longest count and clears the activate bit,
  // so an expiry also disarms a watchdog that software had enabled.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r         <= 7'h7F;
      act_r         <= 1'b0;
      wdog_expire_r <= 1'b0;
      swrst_fire_r  <= 1'b0;
    end else if (stab_busy) begin
      cnt_r         <= 7'h7F;
      act_r         <= 1'b0;
      wdog_expire_r <= 1'b0;
      swrst_fire_r  <= 1'b0;
    end else begin
      cnt_r         <= cnt_nxt;
      act_r         <= act_nxt;
      wdog_expire_r <= expire_nxt;
      swrst_fire_r  <= swrst_nxt;
    end
  end

// ==========================================================================
// Stop handling
// ==========================================================================
  assign stop_enter = stop_request && !watchdog_active;
  assign wait_enter = stop_request && watchdog_active;

  reg stopped_nxt;

  // A stop taken in the same cycle as a wake-up still wins, so the wake
  // that follows is the one that releases the counter.
  always @* begin
    stopped_nxt = stopped_r;
    if (stop_enter) begin
      stopped_nxt = 1'b1;
    end else if (wake_interrupt) begin
      stopped_nxt = 1'b0;
    end
  end

  // A reset always leaves the core running, never stopped.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stopped_r <= 1'b0;
    end else if (stab_busy) begin
      stopped_r <= 1'b0;
    end else begin
      stopped_r <= stopped_nxt;
    end
  end

// ==========================================================================
// Data space read port
// ==========================================================================
  reg [7:0] rdata_nxt;
  reg       hit_nxt;

  // Only the watchdog register answers here; every other address in the
  // data space belongs to some other block and reads back as zero.
  always @* begin
    rdata_nxt = 8'h00;
    hit_nxt   = 1'b0;
    if (data_read && is_wdog_addr(data_addr)) begin
      rdata_nxt = reg_view;
      hit_nxt   = 1'b1;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      data_rdata <= 8'h00;
      data_hit   <= 1'b0;
    end else begin
      data_rdata <= rdata_nxt;
      data_hit   <= hit_nxt;
    end
  end
endmodule // reset_and_watchdog

// *** design/reset_and_watchdog_regs.vh ***
`ifndef RESET_AND_WATCHDOG_REGS_VH
`define RESET_AND_WATCHDOG_REGS_VH

// ==========================================================================
// Register map
// ==========================================================================
`define WDOG_REG_ADDR       8'hD8
`define WDOG_REG_RESET      8'hFE
`define WDOG_ACT_BIT        0
`define WDOG_SWRST_BIT      1

// ==========================================================================
// Timer 1 reset values
// ==========================================================================
`define TMR1_CTRL_RESET     8'h00
`define TMR1_COUNT_RESET    8'hFF
`define TMR1_PRESC_RESET    7'h7F

// ==========================================================================
// Initialisation values and timing
// ==========================================================================
`define RESET_VECTOR        12'hFFE
`define STAB_CYCLES         2048
`define WDOG_TICK_CYCLES    12
`define WDOG_STEP_CYCLES    3072

`endif

// *** design/stab_counter.v ***
`timescale 1ns/1ns
// ==========================================================================
// Stabilisation delay counter
// ==========================================================================
// Holds busy high while any reset source is active and for a fixed number
// of clock cycles after all of them have gone away.
module stab_counter #(
  parameter CYCLES = 2048,
  parameter WIDTH  = 12
) (
  input  wire clock,
  input  wire rst_b,
  input  wire hold,
  output wire busy
);
  reg [WIDTH-1:0] cnt_r;
  reg [WIDTH-1:0] cnt_nxt;
  localparam integer     LOAD_I = CYCLES;
  localparam [WIDTH-1:0] LOAD   = LOAD_I[WIDTH-1:0];

  always @* begin
    if (hold) begin
      cnt_nxt = LOAD;
    end else if (cnt_r != {WIDTH{1'b0}}) begin
      cnt_nxt = cnt_r - 1'b1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= LOAD;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = (cnt_r != {WIDTH{1'b0}});
endmodule // stab_counter

// *** verif/reset_and_watchdog_asserts.sv ***
`timescale 1ns/1ns
module reset_and_watchdog_asserts #(
  parameter STAB_CYCLES = 2048
) (
  input wire        clock,
  input wire        rst_b,
  input wire        ext_reset_b,
  input wire        hw_watchdog_option,
  input wire [7:0]  data_addr,
  input wire [7:0]  data_wdata,
  input wire        data_write,
  input wire        data_read,
  input wire        stop_request,
  input wire        interrupt_pending,
  input wire        return_from_interrupt,
  input wire        data_hit,
  input wire        osc_restart,
  input wire        init_strobe,
  input wire [11:0] reset_pc,
  input wire        stack_clear,
  input wire        nmi_context,
  input wire        service_pending,
  input wire        stop_enter,
  input wire        wait_enter,
  input wire [7:0]  tmr1_ctrl,
  input wire [7:0]  tmr1_count,
  input wire [6:0]  tmr1_presc,
  input wire        watchdog_active,
  input wire        internal_reset
);
  logic [15:0] quiet_r;
  // Counts the held cycles after every source has gone away.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      quiet_r <= 16'h0000;
    else if (osc_restart || !internal_reset)
      quiet_r <= 16'h0000;
    else
      quiet_r <= quiet_r + 16'h0001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence init_pulse;
    init_strobe ##1 !init_strobe;
  endsequence
  a_pin_holds_reset:
    assert property (!ext_reset_b [*3] |-> internal_reset)
    else $error("pin low without reset");
  a_stab_length:
    assert property ($fell(internal_reset) |->
      quiet_r >= STAB_CYCLES - 2 && quiet_r <= STAB_CYCLES + 2)
    else $error("bad stabilisation length");
  a_init_vector:
    assert property ($fell(internal_reset) |-> stack_clear &&
      nmi_context && reset_pc == 12'hFFE ##1 init_pulse)
    else $error("bad initialisation");
  a_timer_values:
    assert property ($past(internal_reset) && internal_reset |->
      tmr1_ctrl == 8'h00 && tmr1_count == 8'hFF && tmr1_presc == 7'h7F)
    else $error("timer not at reset values");
  a_stop_allowed:
    assert property (stop_request && !watchdog_active |-> stop_enter)
    else $error("stop refused");
  a_stop_as_wait:
    assert property (hw_watchdog_option && stop_request |->
      wait_enter && !stop_enter && watchdog_active)
    else $error("stop not turned into wait");
  a_return_from_interrupt_exit:
    assert property (nmi_context && return_from_interrupt &&
      !internal_reset |=> !nmi_context &&
      service_pending == $past(interrupt_pending))
    else $error("bad return from interrupt");
  a_read_answer:
    assert property (data_read && data_addr == 8'hD8 &&
      !internal_reset |=> data_hit)
    else $error("read not answered");
  a_act_sticky:
    assert property (watchdog_active && !internal_reset |=>
      watchdog_active || internal_reset)
    else $error("watchdog disabled by software");
  a_sr_fires:
    assert property (data_write && data_addr == 8'hD8 &&
      !data_wdata[1] && !internal_reset |-> ##[1:4] internal_reset)
    else $error("software reset missing");
endmodule // reset_and_watchdog_asserts

bind reset_and_watchdog reset_and_watchdog_asserts #(
  .STAB_CYCLES(STAB_CYCLES)
) chk (.clock, .rst_b, .ext_reset_b, .hw_watchdog_option, .data_addr,
  .data_wdata, .data_write, .data_read, .stop_request,
  .interrupt_pending, .return_from_interrupt, .data_hit, .osc_restart,
  .init_strobe, .reset_pc, .stack_clear, .nmi_context, .service_pending,
  .stop_enter, .wait_enter, .tmr1_ctrl, .tmr1_count, .tmr1_presc,
  .watchdog_active, .internal_reset);

// *** verif/reset_and_watchdog_test.sv ***
`timescale 1ns/1ns
module reset_and_watchdog_test;
  logic clock = 1'h0, rst_b = 1'h0, osc_running = 1'h0, fire = 1'h0;
  logic hw_watchdog_option = 1'h0, data_write = 1'h0, data_read = 1'h0;
  logic stop_request = 1'h0, wake_interrupt = 1'h0;
  logic interrupt_pending = 1'h0, return_from_interrupt = 1'h0;
  logic [7:0] data_addr = 8'h00, data_wdata = 8'h00;
  logic ext_reset_b, data_hit, core_halt, io_pullup_inputs, osc_restart;
  logic init_strobe, stack_clear, nmi_context, service_pending;
  logic stop_enter, wait_enter, watchdog_active, internal_reset;
  logic [7:0] data_rdata, tmr1_ctrl, tmr1_count, exp_q[$], v;
  logic [11:0] reset_pc;
  logic [6:0] tmr1_presc;
  logic [5:0] n;
  int num_errors = 0, comparisons = 0, i;
  always #5 clock = ~clock;
  reset_and_watchdog #(.STAB_CYCLES(16), .TICK_CYCLES(1)) DUT (.clock,
    .rst_b, .ext_reset_b, .osc_running, .hw_watchdog_option, .data_addr,
    .data_wdata, .data_write, .data_read, .stop_request, .wake_interrupt,
    .interrupt_pending, .return_from_interrupt, .data_rdata, .data_hit,
    .core_halt, .io_pullup_inputs, .osc_restart, .init_strobe, .reset_pc,
    .stack_clear, .nmi_context, .service_pending, .stop_enter, .wait_enter,
    .tmr1_ctrl, .tmr1_count, .tmr1_presc, .watchdog_active,
    .internal_reset);
  reset_pin_driver pin (.clock, .fire, .low_len(4'h3), .ext_reset_b);
  task automatic chk(input logic [22:0] seen, input logic [22:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clock);
    data_addr <= 8'hD8;
    data_wdata <= d;
    data_write <= 1'h1;
    @(posedge clock);
    data_write <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    data_addr <= a;
    data_read <= 1'h1;
    if (a == 8'hD8)
      exp_q.push_back(e);
    @(posedge clock);
    data_read <= 1'h0;
  endtask
  task automatic wait_rel;
    for (i = 0; i < 500 && internal_reset !== 1'h0; i++)
      @(negedge clock);
    chk(internal_reset, 1'h0);
  endtask
  // ==========================================================
  // Read checker: unexpected answers find the queue empty
  // ==========================================================
  always @(negedge clock) begin
    if (data_hit === 1'h1) begin
      if (exp_q.size() == 0)
        chk(1'h1, 1'h0);
      else
        chk(data_rdata, exp_q.pop_front());
    end
  end
  initial begin
    #1000000;
    num_errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h99FDAC83));
    repeat (16) @(posedge clock);
    rst_b <= 1'h1;
    repeat (40) @(posedge clock);
    chk(internal_reset, 1'h1);
    chk({core_halt, io_pullup_inputs, osc_restart}, 3'h7);
    osc_running <= 1'h1;
    wait_rel;
    chk({core_halt, io_pullup_inputs, osc_restart}, 3'h0);
    chk(reset_pc, 12'hFFE);
    chk({tmr1_ctrl, tmr1_count, tmr1_presc}, 23'h007FFF);
    chk({nmi_context, watchdog_active}, 2'h2);
    rd(8'hD8, 8'hFE);
    rd(8'hD7, 8'h00);
    stop_request <= 1'h1;
    @(negedge clock) chk(stop_enter, 1'h1);
    @(posedge clock);
    stop_request <= 1'h0;
    interrupt_pending <= 1'h1;
    return_from_interrupt <= 1'h1;
    wake_interrupt <= 1'h1;
    @(posedge clock);
    return_from_interrupt <= 1'h0;
    wake_interrupt <= 1'h0;
    interrupt_pending <= 1'h0;
    @(negedge clock) chk({service_pending, nmi_context}, 2'h2);
    // Expiry must land (n+1) count steps after the last reload.
    for (int k = 0; k < 3; k++) begin
      n = (k == 0) ? 6'h00 : (k == 1) ? 6'h01 : 6'($urandom);
      v = {{<<{n}}, 2'h3};
      wr(v);
      wr(v & 8'hFE);
      rd(8'hD8, v);
      for (i = 2; i < 20000 && internal_reset !== 1'h1; i++)
        @(negedge clock);
      i = i - (n + 1) * 256;
      chk(i >= -4 && i <= 4, 1'h1);
      wait_rel;
      rd(8'hD8, 8'hFE);
      chk(watchdog_active, 1'h0);
    end
    wr(8'hFC);
    repeat (4) @(posedge clock);
    chk(internal_reset, 1'h1);
    wait_rel;
    @(posedge clock);
    fire <= 1'h1;
    hw_watchdog_option <= 1'h1;
    @(posedge clock);
    fire <= 1'h0;
    repeat (4) @(posedge clock);
    chk(internal_reset, 1'h1);
    wait_rel;
    wr(8'hFE);
    rd(8'hD8, 8'hFF);
    stop_request <= 1'h1;
    @(negedge clock) chk({wait_enter, stop_enter}, 2'h2);
    @(posedge clock);
    stop_request <= 1'h0;
    repeat (4) @(posedge clock);
    end_of_test;
  end
endmodule // reset_and_watchdog_test

// *** verif/reset_pin_driver.sv ***
`timescale 1ns/1ns
// ==========================================================
// Board reset circuit
// ==========================================================
module reset_pin_driver (
  input  wire       clock,
  input  wire       fire,
  input  wire [3:0] low_len,
  output logic      ext_reset_b
);
  logic [3:0] left_r = 4'h0;
  // The pin has a pull-up, so it rests high between pulses.
  assign ext_reset_b = (left_r == 4'h0);
  always @(posedge clock) begin
    if (fire)
      left_r <= low_len;
    else if (left_r != 4'h0)
      left_r <= left_r - 4'h1;
  end
endmodule // reset_pin_driver
